// file: tb_ubg_ctrl.sv
// Purpose: Bench of the port control block.
// Assumes: One access in flight; sampled at falling edges.
// Notes:   Rates counted over windows, +-2 tick and +-1 bit slack.
`timescale 1ns/1ps
module tb_ubg_ctrl
    import ubg_pkg::*;
;
    localparam int LIMIT = 60000;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic baud16_tick, bit_tick, rts_n, dtr_n, loopback, irq;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, tick_cnt, bit_cnt, rd_word;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
    ubg_src_t src_evt, ev_req;
    int fail_count = 0, comparisons = 0, cycles = 0;

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    ubg_ctrl i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .src_evt, .baud16_tick, .bit_tick, .rts_n, .dtr_n,
        .loopback, .irq);
    ubg_line_model i_line (.aclk, .aresetn, .req(ev_req), .baud16_tick,
        .bit_tick, .src_evt, .tick_cnt, .bit_cnt);

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic ga, gw, done;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge aclk);
            done = s_axi_bvalid;
            last_resp = s_axi_bresp;
            ga = s_axi_awready;
            gw = s_axi_wready;
            @(posedge aclk);
            if (ga) s_axi_awvalid <= 1'b0;
            if (gw) s_axi_wvalid <= 1'b0;
        end while (!done);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [5:0] a);
        logic ga, done;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge aclk);
            done = s_axi_rvalid;
            rd_word = s_axi_rdata;
            last_resp = s_axi_rresp;
            ga = s_axi_arready;
            @(posedge aclk);
            if (ga) s_axi_arvalid <= 1'b0;
        end while (!done);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e,
                          input string n);
        rd(a);
        check(n, rd_word, {24'h00_0000, e});
    endtask

    task automatic fire(input logic [4:0] v);
        ev_req <= ubg_src_t'(v);
        @(posedge aclk);
        ev_req <= ubg_src_t'(5'h00);
        repeat (3) @(posedge aclk);
    endtask

    task automatic chk_irq(input logic e, input string n);
        @(negedge aclk);
        check(n, {31'h0, irq}, {31'h0, e});
        @(posedge aclk);
    endtask

    task automatic t_regs;
        logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
        rd_chk(OFS_DIV_LOW, RST_DIV_LOW, "divisor low reset");
        rd_chk(OFS_DIV_HIGH, RST_DIV_HIGH, "divisor high reset");
        rd_chk(OFS_IRQ_IDENT, {4'h0, ID_NONE}, "ident reset");
        wr(OFS_IRQ_EN, 8'hFF);
        rd_chk(OFS_IRQ_EN, 8'h0F, "enable upper bits");
        foreach (pat[i]) begin
            wr(OFS_SCRATCH, pat[i]);
            rd_chk(OFS_SCRATCH, pat[i], "scratch");
        end
        check("irq quiet", {31'h0, irq}, 32'h0000_0000);
        wr(6'h3C, 8'h55);
        check("unmapped write", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
        rd_chk(6'h3C, 8'h00, "unmapped read");
        check("unmapped read", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
        wr(OFS_MODEM_CTL, 8'h13);
        check("loopback", {29'h0, loopback, rts_n, dtr_n}, 32'h0000_0007);
        wr(OFS_MODEM_CTL, 8'h03);
        check("modem out", {29'h0, loopback, rts_n, dtr_n}, 32'h0000_0000);
        $display("test registers finished");
    endtask

    task automatic t_src;
        wr(OFS_EVT_MASK, 8'h1F);
        wr(OFS_MODEM_CTL, 8'h08);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_IRQ_EN, 8'h01 << i);
            fire(5'h0F & ~(5'h01 << i));
            chk_irq(1'b0, "irq other source");
            fire(5'h01 << i);
            chk_irq(1'b1, "irq own source");
            wr(OFS_EVT_STAT, 8'h1F);
            chk_irq(1'b0, "irq cleared");
        end
        wr(OFS_MODEM_CTL, 8'h00);
        wr(OFS_IRQ_EN, 8'h0F);
        fire(5'h1F);
        chk_irq(1'b0, "irq output off");
        wr(OFS_MODEM_CTL, 8'h08);
        chk_irq(1'b1, "irq output on");
        wr(OFS_IRQ_EN, 8'h00);
        chk_irq(1'b0, "irq all off");
        rd_chk(OFS_IRQ_IDENT, {4'h0, ID_NONE}, "ident all off");
        $display("test sources finished");
    endtask

    task automatic t_prio;
        logic [4:0] clr [5] = '{5'h04, 5'h10, 5'h01, 5'h02, 5'h08};
        logic [3:0] id [5] = '{ID_TIMEOUT, ID_RX, ID_TX, ID_MODEM, ID_NONE};
        wr(OFS_IRQ_EN, 8'h0F);
        rd_chk(OFS_IRQ_IDENT, {4'h0, ID_LINE}, "ident first");
        foreach (clr[i]) begin
            wr(OFS_EVT_STAT, {3'h0, clr[i]});
            rd_chk(OFS_IRQ_IDENT, {4'h0, id[i]}, "ident order");
        end
        $display("test priority finished");
    endtask

    task automatic t_rate(input logic [1:0] pd, input logic hs,
                          input logic [15:0] dv, input int n, e);
        logic [31:0] t0, b0;
        int dt, db;
        wr(OFS_PREDIV, {6'h00, pd});
        wr(OFS_HIGHSPEED, {7'h00, hs});
        wr(OFS_DIV_LOW, dv[7:0]);
        wr(OFS_DIV_HIGH, dv[15:8]);
        t0 = tick_cnt;
        b0 = bit_cnt;
        repeat (n) @(posedge aclk);
        dt = int'(tick_cnt - t0);
        db = int'(bit_cnt - b0);
        check("tick rate", {31'h0, dt >= e - 2 && dt <= e + 2}, 32'h1);
        check("bit rate", {31'h0, db >= e / 16 - 1 && db <= e / 16 + 1},
              32'h1);
        $display("test rate %0d finished", dv);
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h000_0000_0000;
        ev_req = ubg_src_t'(5'h00);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_src();
        t_prio();
        t_rate(2'h0, 1'b0, 16'h0001, 6500, 240);
        t_rate(2'h0, 1'b0, 16'h000C, 6500, 20);
        t_rate(2'h1, 1'b0, 16'h0002, 6500, 960);
        t_rate(2'h2, 1'b0, 16'h0003, 5000, 800);
        t_rate(2'h0, 1'b1, 16'h0003, 5000, 800);
        t_rate(2'h2, 1'b0, 16'h0100, 6400, 12);
        summarize();
    end
endmodule // tb_ubg_ctrl

// file: ubg_baud_gen.sv
// Purpose: Reference clock synthesis, divisor and 16x / bit enables.
// Assumes: Single aclk; ticks are one-cycle enables, never clocks.
// Notes:   Accumulator keeps the mean reference rate exact.
`timescale 1ns/1ps
module ubg_baud_gen
    import ubg_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire ubg_baud_cfg_t cfg,
    output logic               tick16,
    output logic               bit_tick
);
    typedef struct packed {
        logic [31:0] acc;
        logic [15:0] ref_cnt;
        logic [3:0]  sub;
        logic        tick16;
        logic        bit_tick;
    } ubg_bg_state_t;

    ubg_bg_state_t st;
    ubg_bg_state_t next_st;
    logic [31:0]   step;
    logic [31:0]   modulus;
    logic [32:0]   sum;
    logic          ref_tick;
    logic [15:0]   last;

    always_comb begin
        next_st = st;
        next_st.tick16 = 1'b0;
        next_st.bit_tick = 1'b0;
        if (cfg.highspeed || cfg.prediv == PREDIV_1) begin
            step = XTAL_HZ * PD1_DEN;
            modulus = CLK_HZ * PD1_NUM;
        end else if (cfg.prediv == PREDIV_1625) begin
            step = XTAL_HZ * PD1625_DEN;
            modulus = CLK_HZ * PD1625_NUM;
        end else begin
            step = XTAL_HZ * PD13_DEN;
            modulus = CLK_HZ * PD13_NUM;
        end
        sum = {1'b0, st.acc} + {1'b0, step};
        ref_tick = (sum >= {1'b0, modulus});
        next_st.acc = ref_tick ? 32'(sum - {1'b0, modulus}) : sum[31:0];
        last = (cfg.divisor == 16'h0000) ? 16'h0000 : cfg.divisor - 16'h0001;
        if (ref_tick) begin
            // compare, not reload: new divisor acts at once
            if (st.ref_cnt >= last) begin
                next_st.ref_cnt = 16'h0000;
                next_st.tick16 = 1'b1;
                next_st.sub = st.sub + 4'h1;
                next_st.bit_tick = (st.sub == OVERSAMPLE_LAST);
            end else begin
                next_st.ref_cnt = st.ref_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick16 = st.tick16;
    assign bit_tick = st.bit_tick;
endmodule // ubg_baud_gen

// file: ubg_ctrl.sv
// Purpose: Register file, interrupt gating and baud control of a port.
// Assumes: AXI4-Lite master keeps one write and one read in flight.
// Notes:   Event inputs are one-cycle pulses.
//
// Notes on behaviour
// - Interrupt enable bits 7 to 4 always read as zero.
// - Enable bit 3 lets modem status changes raise the interrupt.
// - Enable bit 2 lets line status errors raise the interrupt.
// - Enable bit 1 lets transmit holding empty raise the interrupt.
// - Enable bit 0 lets receive data ready raise the interrupt.
// - All four enable bits clear means no interrupt at all.
// - Each source but receive timeout, which shares bit 0, is gated by its own enable bit.
// - Normal speed divides 24 MHz by the pre-divider, then by the divisor.
// - Generator output is sixteen times the bit rate for both paths.
// - High speed divides 24 MHz directly by the same divisor.
// - Pre-divider selects 13, 1.625 or 1 per port.
// - Scratch byte stores and returns any byte, no side effect.
// - Modem control bit 3 must also be set to drive the interrupt.
// - Ident reports line, receive, transmit, then modem by priority.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ubg_ctrl
    import ubg_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    // AXI4-Lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // AXI4-Lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    // AXI4-Lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // Line datapath side
    input  wire ubg_src_t          src_evt,
    output logic                   baud16_tick,
    output logic                   bit_tick,
    output logic                   rts_n,
    output logic                   dtr_n,
    output logic                   loopback,
    output logic                   irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_got;
        logic [31:0]       w_data;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [IE_W-1:0]   irq_en;
        logic [7:0]        div_low;
        logic [7:0]        div_high;
        logic [7:0]        scratch;
        logic [MCR_W-1:0]  mcr;
        ubg_prediv_t       prediv;
        logic              highspeed;
        ubg_src_t          status;
        ubg_src_t          mask;
        logic [3:0]        ident;
        logic              irq;
    } ubg_ctrl_state_t;

    ubg_ctrl_state_t st;
    ubg_ctrl_state_t next_st;

    ubg_baud_cfg_t   baud_cfg;
    ubg_src_t        enable_vec;
    ubg_src_t        pending;
    ubg_src_t        w1c;
    logic [3:0]      ident_now;
    logic            wr_fire;
    logic            rd_fire;
    logic            master_en;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        // Map is dense and word aligned up to the mask register
        return (a <= OFS_EVT_MASK) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction

    // ----------------------------------------------------------------
    // Interrupt gating
    // ----------------------------------------------------------------
    always_comb begin
        enable_vec.rx_ready   = st.irq_en[0];
        enable_vec.tx_empty   = st.irq_en[1];
        enable_vec.line_err   = st.irq_en[2];
        enable_vec.modem_chg  = st.irq_en[3];
        // Timeout shares the receive data enable
        enable_vec.rx_timeout = st.irq_en[0];
    end

    assign pending = st.status & enable_vec;
    assign master_en = st.mcr[MCR_IRQ_OUT];

    ubg_irq_prio u_prio (
        .pending (pending),
        .ident   (ident_now)
    );

    // ----------------------------------------------------------------
    // Baud generator
    // ----------------------------------------------------------------
    always_comb begin
        baud_cfg.highspeed = st.highspeed;
        baud_cfg.prediv    = st.prediv;
        baud_cfg.divisor   = {st.div_high, st.div_low};
    end

    ubg_baud_gen u_baud (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .cfg      (baud_cfg),
        .tick16   (baud16_tick),
        .bit_tick (bit_tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    assign wr_fire = st.aw_got && st.w_got && !st.bvalid;
    assign rd_fire = s_axi_arvalid && !st.rvalid;

    always_comb begin
        next_st = st;
        w1c = '0;

        // Address and data may arrive in either order
        if (s_axi_awvalid && !st.aw_got && !st.bvalid) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got && !st.bvalid) begin
            next_st.w_got   = 1'b1;
            next_st.w_data  = s_axi_wdata;
            next_st.w_lane0 = s_axi_wstrb[0];
        end

        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = is_mapped(st.aw_addr) ? RESP_OKAY
                                                   : RESP_SLVERR;
            if (st.w_lane0) begin
                if (st.aw_addr == OFS_IRQ_EN) begin
                    next_st.irq_en = st.w_data[IE_W-1:0];
                end else if (st.aw_addr == OFS_DIV_LOW) begin
                    // takes effect on the next compare
                    next_st.div_low = st.w_data[7:0];
                end else if (st.aw_addr == OFS_DIV_HIGH) begin
                    next_st.div_high = st.w_data[7:0];
                end else if (st.aw_addr == OFS_SCRATCH) begin
                    next_st.scratch = st.w_data[7:0];
                end else if (st.aw_addr == OFS_MODEM_CTL) begin
                    next_st.mcr = st.w_data[MCR_W-1:0];
                end else if (st.aw_addr == OFS_PREDIV) begin
                    // unused code falls back to 13
                    if (st.w_data[1:0] == PREDIV_1625) begin
                        next_st.prediv = PREDIV_1625;
                    end else if (st.w_data[1:0] == PREDIV_1) begin
                        next_st.prediv = PREDIV_1;
                    end else begin
                        next_st.prediv = PREDIV_13;
                    end
                end else if (st.aw_addr == OFS_HIGHSPEED) begin
                    next_st.highspeed = st.w_data[0];
                end else if (st.aw_addr == OFS_EVT_STAT) begin
                    w1c = st.w_data[$bits(ubg_src_t)-1:0];
                end else if (st.aw_addr == OFS_EVT_MASK) begin
                    next_st.mask = st.w_data[$bits(ubg_src_t)-1:0];
                end
            end
        end

        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        if (rd_fire) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY
                                                     : RESP_SLVERR;
            if (s_axi_araddr == OFS_IRQ_EN) begin
                next_st.rdata = byte_word({4'h0, st.irq_en});
            end else if (s_axi_araddr == OFS_DIV_LOW) begin
                next_st.rdata = byte_word(st.div_low);
            end else if (s_axi_araddr == OFS_DIV_HIGH) begin
                next_st.rdata = byte_word(st.div_high);
            end else if (s_axi_araddr == OFS_SCRATCH) begin
                next_st.rdata = byte_word(st.scratch);
            end else if (s_axi_araddr == OFS_MODEM_CTL) begin
                next_st.rdata = byte_word({3'h0, st.mcr});
            end else if (s_axi_araddr == OFS_IRQ_IDENT) begin
                next_st.rdata = byte_word({4'h0, st.ident});
            end else if (s_axi_araddr == OFS_PREDIV) begin
                next_st.rdata = byte_word({6'h00, st.prediv});
            end else if (s_axi_araddr == OFS_HIGHSPEED) begin
                next_st.rdata = byte_word({7'h00, st.highspeed});
            end else if (s_axi_araddr == OFS_EVT_STAT) begin
                next_st.rdata = byte_word({3'h0, st.status});
            end else if (s_axi_araddr == OFS_EVT_MASK) begin
                next_st.rdata = byte_word({3'h0, st.mask});
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end

        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // New events win over a clear in the same cycle
        next_st.status = (st.status & ~w1c) | src_evt;

        next_st.ident = ident_now;

        // no enabled source or no master, no interrupt
        next_st.irq = master_en && |(pending & st.mask);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st          <= '0;
            st.div_low  <= RST_DIV_LOW;
            st.div_high <= RST_DIV_HIGH;
            st.prediv   <= PREDIV_13;
            st.ident    <= ID_NONE;
            st.bresp    <= RESP_OKAY;
            st.rresp    <= RESP_OKAY;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready  = !st.w_got && !st.bvalid;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    // Modem pins are active low; loopback forces them inactive
    assign rts_n    = !(st.mcr[MCR_RTS] && !st.mcr[MCR_LOOPBACK]);
    assign dtr_n    = !(st.mcr[MCR_DTR] && !st.mcr[MCR_LOOPBACK]);
    assign loopback = st.mcr[MCR_LOOPBACK];
    assign irq      = st.irq;

endmodule // ubg_ctrl

// file: ubg_ctrl_monitor.sv
// Purpose: Port checks of the control block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound into each control block.
`timescale 1ns/1ps
module ubg_ctrl_monitor
    import ubg_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        baud16_tick,
    input wire logic        bit_tick,
    input wire logic        rts_n,
    input wire logic        dtr_n,
    input wire logic        loopback
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_tick_align: assert property (bit_tick |-> baud16_tick)
        else $error("lone bit tick");
    // Fastest reference still leaves a gap
    chk_tick_gap: assert property (baud16_tick |=> !baud16_tick)
        else $error("ticks adjacent");
    chk_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read while busy");
    chk_byte_data: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper bits set");
    chk_write_latency: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write late");
    chk_write_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write while busy");
    chk_loop_quiet: assert property (loopback |-> rts_n && dtr_n)
        else $error("modem pins in loopback");
endmodule // ubg_ctrl_monitor

bind ubg_ctrl ubg_ctrl_monitor i_mon (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .baud16_tick, .bit_tick, .rts_n, .dtr_n, .loopback);

// file: ubg_irq_prio.sv
// Purpose: Priority encoding of pending, enabled interrupt sources.
// Assumes: Inputs already gated by the per-source enables.
// Notes:   Pure logic; the caller registers the result.
`timescale 1ns/1ps
module ubg_irq_prio
    import ubg_pkg::*;
(
    input  wire ubg_src_t   pending,
    output logic [3:0]      ident
);
    always_comb begin
        if (pending.line_err) begin
            ident = ID_LINE;
        end else if (pending.rx_timeout) begin
            ident = ID_TIMEOUT;
        end else if (pending.rx_ready) begin
            ident = ID_RX;
        end else if (pending.tx_empty) begin
            ident = ID_TX;
        end else if (pending.modem_chg) begin
            ident = ID_MODEM;
        end else begin
            ident = ID_NONE;
        end
    end
endmodule // ubg_irq_prio

// file: ubg_line_model.sv
// Purpose: Line side stand-in: event pulses, tick counts.
// Assumes: The bench holds each request for exactly one cycle.
// Notes:   Counters wrap; windows are far shorter.
`timescale 1ns/1ps
module ubg_line_model
    import ubg_pkg::*;
(
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire ubg_src_t req,
    input  wire logic     baud16_tick,
    input  wire logic     bit_tick,
    output ubg_src_t      src_evt,
    output logic [31:0]   tick_cnt,
    output logic [31:0]   bit_cnt
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_evt  <= '0;
            tick_cnt <= '0;
            bit_cnt  <= '0;
        end else begin
            src_evt  <= req;
            tick_cnt <= tick_cnt + 32'(baud16_tick);
            bit_cnt  <= bit_cnt + 32'(bit_tick);
        end
    end
endmodule // ubg_line_model

// file: ubg_pkg.sv
// Purpose: Shared constants and types for the serial port control block.
// Assumes: 32-bit AXI4-Lite data, one aligned word per register.
// Notes:   Status and mask registers share the event source layout.
package ubg_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] OFS_IRQ_EN    = 6'h00;
    localparam logic [5:0] OFS_DIV_LOW   = 6'h04;
    localparam logic [5:0] OFS_DIV_HIGH  = 6'h08;
    localparam logic [5:0] OFS_SCRATCH   = 6'h0C;
    localparam logic [5:0] OFS_MODEM_CTL = 6'h10;
    localparam logic [5:0] OFS_IRQ_IDENT = 6'h14;
    localparam logic [5:0] OFS_PREDIV    = 6'h18;
    localparam logic [5:0] OFS_HIGHSPEED = 6'h1C;
    localparam logic [5:0] OFS_EVT_STAT  = 6'h20;
    localparam logic [5:0] OFS_EVT_MASK  = 6'h24;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int unsigned IE_W         = 4;
    localparam int unsigned MCR_W        = 5;
    localparam int unsigned MCR_IRQ_OUT  = 3;
    localparam int unsigned MCR_LOOPBACK = 4;
    localparam int unsigned MCR_RTS      = 1;
    localparam int unsigned MCR_DTR      = 0;
    localparam logic [7:0] RST_DIV_LOW   = 8'h0C;
    localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // Identification codes, low nibble of the ident register
    localparam logic [3:0] ID_NONE    = 4'h1;
    localparam logic [3:0] ID_LINE    = 4'h6;
    localparam logic [3:0] ID_RX      = 4'h4;
    localparam logic [3:0] ID_TIMEOUT = 4'hC;
    localparam logic [3:0] ID_TX      = 4'h2;
    localparam logic [3:0] ID_MODEM   = 4'h0;

    // ----------------------------------------------------------------
    // Rates: reference = XTAL_HZ * DEN / NUM, made from CLK_HZ
    // ----------------------------------------------------------------
    localparam logic [31:0] CLK_HZ  = 32'd50_000_000;
    localparam logic [31:0] XTAL_HZ = 32'd24_000_000;
    localparam logic [31:0] PD13_NUM = 32'd13;
    localparam logic [31:0] PD13_DEN = 32'd1;
    localparam logic [31:0] PD1625_NUM = 32'd13;
    localparam logic [31:0] PD1625_DEN = 32'd8;
    localparam logic [31:0] PD1_NUM = 32'd1;
    localparam logic [31:0] PD1_DEN = 32'd1;
    localparam logic [3:0]  OVERSAMPLE_LAST = 4'hF;

    typedef enum logic [1:0] {PREDIV_13, PREDIV_1625, PREDIV_1} ubg_prediv_t;

    // First member is the top bit: rx_ready lands on bit 0
    typedef struct packed {
        logic rx_timeout;
        logic modem_chg;
        logic line_err;
        logic tx_empty;
        logic rx_ready;
    } ubg_src_t;

    typedef struct packed {
        logic        highspeed;
        ubg_prediv_t prediv;
        logic [15:0] divisor;
    } ubg_baud_cfg_t;

endpackage
